// ==== ppm_pkg.sv ====
package ppm_pkg;
  // Register indices: printed offsets 0x...3010 to 0x...301e are not all
  // multiples of four, so each is an index and the byte address is 4*index
  localparam logic [31:0] PPM_IDX_PIN5_MODE      = 32'h50003010;
  localparam logic [31:0] PPM_IDX_PIN6_MODE      = 32'h50003012;
  localparam logic [31:0] PPM_IDX_PIN7_MODE      = 32'h50003014;
  localparam logic [31:0] PPM_IDX_PIN8_MODE      = 32'h50003016;
  localparam logic [31:0] PPM_IDX_PIN9_MODE      = 32'h50003018;
  localparam logic [31:0] PPM_IDX_PIN10_MODE     = 32'h5000301a;
  localparam logic [31:0] PPM_IDX_PIN11_MODE     = 32'h5000301c;
  localparam logic [31:0] PPM_IDX_DRIVE_REDUCE   = 32'h5000301e;
  // Local window: low address bits decoded (byte addr = idx*4)
  localparam int          PPM_ADDR_W             = 8;
  // Local byte offset of a register from its index
  localparam logic [7:0]  PPM_OFF_PIN5           = 8'h40;
  localparam logic [7:0]  PPM_OFF_STEP           = 8'h08;
  localparam logic [7:0]  PPM_OFF_DRIVE          = 8'h78;
  // Pin range handled here
  localparam int          PPM_FIRST_PIN          = 5;
  localparam int          PPM_NUM_MODE           = 7;
  localparam int          PPM_NUM_PADS           = 12;
  // Mode register fields
  localparam int          PPM_PULL_LSB           = 8;
  localparam int          PPM_PULL_MSB           = 9;
  localparam int          PPM_FUNC_MSB           = 4;
  localparam logic [15:0] PPM_MODE_WMASK         = 16'h031f;
  localparam logic [15:0] PPM_DRIVE_WMASK        = 16'h0fff;
  localparam logic [1:0]  PPM_PULL_NONE          = 2'h0;
  localparam logic [1:0]  PPM_PULL_UP            = 2'h1;
  localparam logic [1:0]  PPM_PULL_DOWN          = 2'h2;
  localparam logic [1:0]  PPM_PULL_OUT           = 2'h3;
  localparam logic [1:0]  PPM_PULL_RESET         = 2'h2;
  localparam logic [4:0]  PPM_FUNC_RESET         = 5'h00;
  localparam logic [4:0]  PPM_FUNC_ANALOG        = 5'h0f;
  localparam logic [11:0] PPM_DRIVE_RESET        = 12'h000;
  // Pins able to take analog converter mode (of 5..11: 6 and 7)
  localparam logic [11:0] PPM_ANALOG_CAPABLE     = 12'h0c0;
  // AXI responses
  localparam logic [1:0]  PPM_RESP_OKAY          = 2'h0;
  localparam logic [1:0]  PPM_RESP_SLVERR        = 2'h2;
endpackage

// ==== ppm_port_config.sv ====
`timescale 1ns/100ps
module ppm_port_config
  import ppm_pkg::*;
#(
  parameter int NUM_FUNC = 32
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [31:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [31:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic [NUM_FUNC-1:0]     func_out,
  output logic [NUM_FUNC-1:0]          func_in,
  input  wire logic [PPM_NUM_MODE-1:0] port_pin_in,
  output logic [PPM_NUM_MODE-1:0]      port_pin_out,
  output logic [PPM_NUM_MODE-1:0]      port_pin_oe_n,
  output logic [PPM_NUM_MODE-1:0]      port_pin_pull_up,
  output logic [PPM_NUM_MODE-1:0]      port_pin_pull_down,
  output logic [PPM_NUM_MODE-1:0]      port_pin_analog,
  output logic [PPM_NUM_PADS-1:0]      pad_drive_reduce
);

  // Block outline
  // Seven mode registers cover pins 5 to 11
  // One drive mask covers all twelve pads
  // Each mode register: pull code plus function code
  // Pull code picks resistors or output drive
  // Function code picks the routed peripheral line
  // Pad controls are flops, one edge after a write
  // Pin levels pass two flops before use
  // Input functions get a third, registered stage
  // Bus side is a small AXI4-Lite slave
  // Only the low address byte is decoded
  // Upper address bits alias onto the same window
  // Hazard: software must not rely on that aliasing

  // Stored fields per pin
  logic [1:0]              pull_reg [PPM_NUM_MODE];      // Pull select
  logic [4:0]              func_reg [PPM_NUM_MODE];      // Function select
  logic [PPM_NUM_PADS-1:0] drive_reg;                    // Drive reduce mask
  // Pin synchroniser stages
  logic [PPM_NUM_MODE-1:0] pin_meta_reg;                 // First stage only
  logic [PPM_NUM_MODE-1:0] pin_sync_reg;                 // Usable pin level
  // Pin output flops
  logic [PPM_NUM_MODE-1:0] pin_out_reg;
  logic [PPM_NUM_MODE-1:0] oe_n_reg;
  logic [PPM_NUM_MODE-1:0] pu_reg;
  logic [PPM_NUM_MODE-1:0] pd_reg;
  logic [PPM_NUM_MODE-1:0] an_reg;
  logic [NUM_FUNC-1:0]     func_in_reg;
  // Bus state
  logic                    aw_held_reg;                  // Write address taken
  logic                    w_held_reg;                   // Write data taken
  logic [31:0]             awaddr_reg;
  logic [31:0]             wdata_reg;
  logic [3:0]              wstrb_reg;
  logic                    bvalid_reg;
  logic [1:0]              bresp_reg;
  logic                    rvalid_reg;
  logic [1:0]              rresp_reg;
  logic [31:0]             rdata_reg;

  // Bus timing in short
  // Address and data may arrive in either order
  // Each half is held until the write commits
  // Commit waits for any pending response to drain
  // Response raised one edge after both halves held
  // Read answers one edge after address taken
  // Read data captured at the address edge
  // No wait states beyond these fixed steps

  // Handshake decode
  wire aw_fire  = s_axi_awvalid && s_axi_awready;
  wire w_fire   = s_axi_wvalid && s_axi_wready;
  wire ar_fire  = s_axi_arvalid && s_axi_arready;
  // Write commits once both halves are held and no response pending
  wire wr_go    = aw_held_reg && w_held_reg && !bvalid_reg;
  // Low-half byte lanes
  wire [15:0] lane_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [7:0]  wr_off    = awaddr_reg[PPM_ADDR_W-1:0];
  wire [7:0]  rd_off    = s_axi_araddr[PPM_ADDR_W-1:0];
  wire        wr_drive  = (wr_off == PPM_OFF_DRIVE);
  wire        rd_drive  = (rd_off == PPM_OFF_DRIVE);

  // Per-pin decode hits and read data
  logic [PPM_NUM_MODE-1:0] wr_hit;
  logic [PPM_NUM_MODE-1:0] rd_hit;
  logic [15:0]             mode_word [PPM_NUM_MODE];

  // Write readies while the matching half is not yet held; read ready while no read data pending
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  wire wr_any = |wr_hit || wr_drive;
  wire rd_any = |rd_hit || rd_drive;

  // Read selection
  // Offsets decode one-hot, so order is harmless
  // Unmapped offsets fall through to zero
  // Drive mask read last, never overlaps a pin
  // Upper half of read data always zero
  // Reserved pin bits come back as zero
  // Mux is purely combinational
  // Captured into read data flop on address edge

  // Read mux of all registers
  logic [15:0] rd_word;
  always_comb begin
    rd_word = '0;
    for (int i = 0; i < PPM_NUM_MODE; i++) begin
      if (rd_hit[i]) begin
        rd_word = mode_word[i];
      end
    end
    if (rd_drive) begin
      rd_word = {4'h0, drive_reg};
    end
  end

  // Per-pin slice
  // One copy per pin, indexed from pin 5
  // Offset grows by one 8-byte step per pin
  // Write merges new bits under the byte lanes
  // Reserved bits are masked before storing
  // Analog test uses the capable-pad table
  // Code 15 elsewhere is an ordinary function
  // Pad controls register the decoded mode
  // Trade: one edge of latency, glitch-free pads
  // Reset state is input with pull-down

  // Per-pin registers and pad logic
  for (genvar p = 0; p < PPM_NUM_MODE; p++) begin : g_pin
    localparam int PAD = p + PPM_FIRST_PIN;
    localparam logic [7:0] OFF = 8'((p + 1) * 8) + PPM_OFF_PIN5 - PPM_OFF_STEP;
    assign wr_hit[p] = (wr_off == OFF);
    assign rd_hit[p] = (rd_off == OFF);
    // Reserved bits read zero
    assign mode_word[p] = {6'h00, pull_reg[p], 3'h0, func_reg[p]};
    // Masked write data, reserved bits dropped
    wire [15:0] wmask = lane_mask & PPM_MODE_WMASK;
    wire [15:0] wnew  = (mode_word[p] & ~wmask) | (wdata_reg[15:0] & wmask);
    // Analog mode only on capable pads
    wire is_an = (func_reg[p] == PPM_FUNC_ANALOG) && PPM_ANALOG_CAPABLE[PAD];

    // Field storage
    // Only pull and function bits exist as flops
    // Reserved bits have no storage at all
    // Writes land on the commit edge only
    // Reset loads pull-down and function zero
    // Bus must not see half-updated fields

    // Mode register storage
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pull_reg[p] <= PPM_PULL_RESET;
        func_reg[p] <= PPM_FUNC_RESET;
      end else if (wr_go && wr_hit[p]) begin
        pull_reg[p] <= wnew[PPM_PULL_MSB:PPM_PULL_LSB];
        func_reg[p] <= wnew[PPM_FUNC_MSB:0];
      end
    end

    // Pad control decode
    // Output enable is active low
    // Driven pin never has a resistor on
    // Pull-up and pull-down never both on
    // Analog pad: no drive and no resistors
    // Output value follows the chosen function
    // Output value updates even while an input
    // Reset releases the pad with pull-down on

    // Pad control from pull select
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        oe_n_reg[p]    <= 1'b1;
        pu_reg[p]      <= 1'b0;
        pd_reg[p]      <= 1'b1;
        an_reg[p]      <= 1'b0;
        pin_out_reg[p] <= 1'b0;
      end else begin
        an_reg[p]      <= is_an;
        // Output value is the selected function's output
        pin_out_reg[p] <= func_out[func_reg[p]];
        // Analog ignores pull select: no drive, no resistors
        oe_n_reg[p]    <= is_an || (pull_reg[p] != PPM_PULL_OUT);
        pu_reg[p]      <= !is_an && (pull_reg[p] == PPM_PULL_UP);
        pd_reg[p]      <= !is_an && (pull_reg[p] == PPM_PULL_DOWN);
        // Code 00 leaves both resistors off
      end
    end
  end

  // Input routing
  // Every function line scans all seven pins
  // Output pins never feed a function
  // Analog pins never feed a function
  // Lowest pin index wins on a clash
  // Unselected function lines read zero
  // Uses synchronised levels only
  // Result registered before leaving block

  // Input function routing, lowest pin wins
  logic [NUM_FUNC-1:0] func_in_next;
  always_comb begin
    func_in_next = '0;
    for (int f = 0; f < NUM_FUNC; f++) begin
      // Walk downward so lowest index is applied last
      for (int p = PPM_NUM_MODE - 1; p >= 0; p--) begin
        if ((pull_reg[p] != PPM_PULL_OUT) && (func_reg[p] == 5'(f))
            && !(func_reg[p] == PPM_FUNC_ANALOG && PPM_ANALOG_CAPABLE[p + PPM_FIRST_PIN])) begin
          func_in_next[f] = pin_sync_reg[p];
        end
      end
    end
  end

  // Synchroniser
  // Pad levels are asynchronous to the clock
  // First stage may go metastable
  // Nothing but the second stage reads the first
  // Three edges from pad to function input
  // Reset clears all stages to low
  // Trade: latency against metastability risk

  // Pin input synchroniser and function input flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      func_in_reg  <= '0;
    end else begin
      pin_meta_reg <= port_pin_in;
      pin_sync_reg <= pin_meta_reg;
      func_in_reg  <= func_in_next;
    end
  end

  // Drive mask
  // Twelve bits, one per pad of the port
  // Bit set gives weak drive on that pad
  // Reset leaves every pad at normal drive
  // Reserved upper bits are never stored
  // Byte lanes respected as for mode words

  // Drive reduce mask register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_reg <= PPM_DRIVE_RESET;
    end else if (wr_go && wr_drive) begin
      // Bits 15:12 dropped
      drive_reg <= (drive_reg & ~(lane_mask[11:0] & PPM_DRIVE_WMASK[11:0]))
                 | (wdata_reg[11:0] & lane_mask[11:0] & PPM_DRIVE_WMASK[11:0]);
    end
  end

  // Write channel
  // Address and data latched independently
  // Ready drops while the half is held
  // Commit clears both held flags together
  // Response stays up until bready is seen
  // Next commit waits for response to drain
  // Unmapped offset: error code, no effect
  // Only one write may be under way
  // Hazard: master must not drop valid early
  // Strobes above the low half are ignored

  // Write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= PPM_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        // Unmapped offsets answer SLVERR
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_any ? PPM_RESP_OKAY : PPM_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel notes
  // Address ready only while no data pending
  // Data and code stand until rready seen
  // Unmapped offset: error code, zero data
  // Only one read may be under way
  // Reads have no side effects

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= PPM_RESP_OKAY;
      rdata_reg  <= '0;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_any ? PPM_RESP_OKAY : PPM_RESP_SLVERR;
      rdata_reg  <= {16'h0000, rd_word};
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Output wiring
  // Every data output comes straight from a flop
  // No logic between flops and ports
  // Pads see stable levels between edges
  // Handshake readies are the only gates

  // Outputs from flops
  assign port_pin_out       = pin_out_reg;
  assign port_pin_oe_n      = oe_n_reg;
  assign port_pin_pull_up   = pu_reg;
  assign port_pin_pull_down = pd_reg;
  assign port_pin_analog    = an_reg;
  assign func_in            = func_in_reg;
  assign pad_drive_reduce   = drive_reg;

endmodule

// ==== ppm_port_config_props.sv ====
`timescale 1ns/100ps
// Port-level checks of the pin configuration block
module ppm_port_config_props
  import ppm_pkg::*;
(
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic [PPM_NUM_MODE-1:0] port_pin_oe_n,
  input wire logic [PPM_NUM_MODE-1:0] port_pin_pull_up,
  input wire logic [PPM_NUM_MODE-1:0] port_pin_pull_down,
  input wire logic [PPM_NUM_MODE-1:0] port_pin_analog,
  input wire logic [PPM_NUM_PADS-1:0] pad_drive_reduce
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data taken together
  sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  // Read address taken
  sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  property p_rst_pins;
    $rose(aresetn) |-> &port_pin_pull_down && &port_pin_oe_n && pad_drive_reduce == 12'h000;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pads not at reset state");
  property p_updn; (port_pin_pull_up & port_pin_pull_down) == 7'h00; endproperty
  a_updn: assert property (p_updn) else $error("both resistors on");
  property p_out_nores; (~port_pin_oe_n & (port_pin_pull_up | port_pin_pull_down)) == 7'h00;
  endproperty
  a_out_nores: assert property (p_out_nores) else $error("driven pin has resistor");
  property p_ana; (port_pin_analog & ~(PPM_ANALOG_CAPABLE[11:5])) == 7'h00
    && (port_pin_analog & (~port_pin_oe_n | port_pin_pull_up | port_pin_pull_down)) == 7'h00;
  endproperty
  a_ana: assert property (p_ana) else $error("analog pin wrong");
  property p_wr_lat; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response late");
  property p_rd_lat; s_rd_taken |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read response late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
endmodule
bind ppm_port_config ppm_port_config_props i_ppm_port_config_props (.*);

// ==== ppm_pad_model.sv ====
`timescale 1ns/100ps
// Circuitry on the pads: outside driver, resistors, floating level
module ppm_pad_model
  import ppm_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic [PPM_NUM_MODE-1:0] pin_out,
  input  wire logic [PPM_NUM_MODE-1:0] oe_n,
  input  wire logic [PPM_NUM_MODE-1:0] pull_up,
  input  wire logic [PPM_NUM_MODE-1:0] pull_down,
  input  wire logic [PPM_NUM_MODE-1:0] ext_en,
  input  wire logic [PPM_NUM_MODE-1:0] ext_val,
  output logic      [PPM_NUM_MODE-1:0] pad
);
  logic [PPM_NUM_MODE-1:0] float_pat; // Undriven pads wander
  initial float_pat = 7'h55;
  // Floating level changes every cycle
  always @(posedge aclk) float_pat <= ~float_pat;
  // Pin driver wins, then outside driver, then resistors
  assign pad = (~oe_n & pin_out) | (oe_n & ext_en & ext_val)
             | (oe_n & ~ext_en & (pull_up | (~pull_down & float_pat)));
endmodule

// ==== testbench.sv ====
`timescale 1ns/100ps
// Register-driven checks of pin modes, drive mask and routing
module testbench
  import ppm_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, func_out, func_in;
  logic [6:0]  port_pin_in, port_pin_out, port_pin_oe_n, port_pin_pull_up, port_pin_pull_down;
  logic [6:0]  port_pin_analog, ext_en, ext_val, exp7;
  logic [11:0] pad_drive_reduce;
  int          error_cnt, samples_checked;
  ppm_port_config i_ppm_port_config (.*);
  ppm_pad_model i_ppm_pad_model (.aclk(aclk), .pin_out(port_pin_out), .oe_n(port_pin_oe_n),
    .pull_up(port_pin_pull_up), .pull_down(port_pin_pull_down), .ext_en(ext_en),
    .ext_val(ext_val), .pad(port_pin_in));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write: address and data offered together, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {24'h0, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    n = 0;
    tb = 1'b0;
    while (!tb && n < 50) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    chk("write response", {tb, r}, {1'b1, er});
  endtask
  // Read: ready raised late so the data must stand
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    n = 0;
    tr = 1'b0;
    while (!tr && n < 50) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      {d, r} = {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (n == 1) s_axi_rready <= 1'b1;
      n++;
    end
    s_axi_rready <= 1'b0;
    chk("read response", {tr, r}, {1'b1, er});
    chk("read data", d, ed);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  function automatic logic [7:0] ma(input int i);
    return PPM_OFF_PIN5 + 8'(i) * PPM_OFF_STEP;
  endfunction
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #1000000;
    error_cnt++;
    end_sim;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, func_out} = 128'h0;
    {s_axi_wstrb, ext_en, ext_val} = {4'hf, 14'h0};
    {error_cnt, samples_checked} = 64'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(ma(i), 32'h200, PPM_RESP_OKAY);
    rd(PPM_OFF_DRIVE, 32'h0, PPM_RESP_OKAY);
    for (int i = 0; i < 7; i++) begin
      wr(ma(i), 32'hffff_ffff, PPM_RESP_OKAY);
      rd(ma(i), 32'h31f, PPM_RESP_OKAY);
    end
    wr(PPM_OFF_DRIVE, 32'hffff_ffff, PPM_RESP_OKAY);
    rd(PPM_OFF_DRIVE, 32'hfff, PPM_RESP_OKAY);
    wr(PPM_OFF_DRIVE, 32'h5, PPM_RESP_OKAY);
    settle(1);
    chk("drive mask", pad_drive_reduce, 32'h5);
    wr(8'h7c, 32'h1, PPM_RESP_SLVERR);
    rd(8'h7c, 32'h0, PPM_RESP_SLVERR);
    $display("register test done");
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 7; i++) wr(ma(i), 32'(c) << 8, PPM_RESP_OKAY);
      settle(1);
      chk("pull up", port_pin_pull_up, c == 1 ? 7'h7f : 7'h0);
      chk("pull down", port_pin_pull_down, c == 2 ? 7'h7f : 7'h0);
      chk("oe_n", port_pin_oe_n, c == 3 ? 7'h0 : 7'h7f);
    end
    for (int i = 0; i < 7; i++) wr(ma(i), 32'h300 + 32'(i + 1), PPM_RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      func_out <= k ? 32'h54 : 32'haa;
      settle(2);
      for (int i = 0; i < 7; i++) exp7[i] = func_out[i + 1];
      chk("pin out", port_pin_out, exp7);
    end
    for (int i = 0; i < 7; i++) wr(ma(i), 32'h9, PPM_RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      @(posedge aclk);
      {ext_en, ext_val} <= {7'h7f, k == 0 ? 7'h08 : k == 1 ? 7'h01 : 7'h7e};
      settle(4);
      chk("routed input", func_in[9], ext_val[0]);
    end
    @(posedge aclk);
    ext_en <= 7'h0;
    wr(ma(0), 32'h30f, PPM_RESP_OKAY);
    wr(ma(1), 32'h30f, PPM_RESP_OKAY);
    wr(ma(2), 32'h20f, PPM_RESP_OKAY);
    settle(1);
    chk("analog", port_pin_analog, 32'h6);
    chk("oe_n", port_pin_oe_n, 32'h7e);
    chk("pull down", port_pin_pull_down, 32'h0);
    @(posedge aclk);
    s_axi_wstrb <= 4'h1;
    wr(ma(4), 32'h305, PPM_RESP_OKAY);
    rd(ma(4), 32'h5, PPM_RESP_OKAY);
    @(posedge aclk);
    s_axi_wstrb <= 4'h2;
    wr(ma(4), 32'h107, PPM_RESP_OKAY);
    rd(ma(4), 32'h105, PPM_RESP_OKAY);
    @(posedge aclk);
    s_axi_wstrb <= 4'hf;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ma(3), 32'h200, PPM_RESP_OKAY);
    $display("pin mode test done");
    end_sim;
  end
endmodule
